// ==== shared/pst_pkg.sv ====
// pst_pkg: constants, states and carrier structs for the power-state and thermal-trip controller
// assumes one core clock domain at 100 MHz with a synchronous active-high reset
`default_nettype none
package pst_pkg;
    localparam int SYNC_STAGES = 3;
    localparam logic [35:0] RESET_VECTOR = 36'hF_FFFF_FFF0;
    // bus release bound after reset is seen, in bus clocks
    localparam int BUS_RELEASE_CLKS = 2;
    localparam logic [1:0] CYC_BUS_OFF = 2'h1;
    // bus transaction codes for special acknowledges
    localparam logic [1:0] TXN_NONE = 2'h0;
    localparam logic [1:0] TXN_STOP_GRANT_ACK = 2'h1;
    localparam logic [1:0] TXN_SMI_ACK = 2'h2;
    localparam logic [2:0] SYNC_RESET_VAL = 3'h7;

    typedef enum logic [2:0] {
        PST_RUN = 3'b000,
        PST_GRANT_ACK = 3'b001,
        PST_STOP_GRANT = 3'b010,
        PST_SLEEP = 3'b011,
        PST_SMI_SAVE = 3'b100,
        PST_SMI_ACK = 3'b101,
        PST_TRIP = 3'b110
    } pst_state_t;

    typedef struct packed {
        logic core;
        logic bus_unit;
        logic apic;
    } pst_clk_en_t;

    typedef struct packed {
        logic valid;
        logic [1:0] code;
    } pst_txn_t;
endpackage
`default_nettype wire

// ==== rtl/pst_ctrl.sv ====
// pst_ctrl: power-state sequencing, management-mode entry and latched overheat trip
// assumes request pins are asynchronous and active low; sensor compare is a level input
// Notes on behaviour
// - stop request enters stop grant, acknowledges
// - stop grant gates core, keeps bus, apic
// - stop grant still snoops and services interrupts
// - stop release restarts clocks, resumes execution
// - stop request asynchronous, bus clock untouched
// - sleep in stop grant stops all clocks
// - sleep ignores snoops, interrupts; watches pins
// - sleep release returns to stop grant
// - accepted management request saves state, enters mode
// - then acknowledge transaction, handler fetch
// - over-temperature halts execution, drives trip
// - trip and halt latched until reset
// - no hysteresis; cool reset restarts at vector
// - still hot keeps trip regardless of reset
// - every cool reset starts at reset vector
// - bus outputs released within two clocks
`default_nettype none
module pst_ctrl
    import pst_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_stop_clock_request_n,
    input wire logic i_sleep_request_n,
    input wire logic i_mgmt_interrupt_n,
    input wire logic i_over_trip_temp,
    input wire logic i_txn_ready,
    input wire logic i_snoop_req,
    input wire logic i_irq_req,
    output logic o_overheat_trip_n,
    output logic o_exec_en,
    output logic o_fetch_start,
    output logic [35:0] o_fetch_addr,
    output logic o_save_state,
    output logic o_system_management_mode,
    output logic o_snoop_ack,
    output logic o_irq_take,
    output logic o_bus_out_en,
    output pst_clk_en_t o_clk_en,
    output pst_txn_t o_txn
);
    logic [SYNC_STAGES-1:0] stop_sync_ff;
    logic [SYNC_STAGES-1:0] sleep_sync_ff;
    logic [SYNC_STAGES-1:0] smi_sync_ff;
    logic stop_req;
    logic sleep_req;
    logic smi_req;
    pst_state_t state_ff;
    pst_state_t nxt_state;
    logic trip_ff;
    logic smm_ff;
    logic smi_pend_ff;
    logic smi_prev_ff;
    logic rst_seen_ff;
    logic fetch_ff;
    logic [35:0] fetch_addr_ff;
    logic snoop_ack_ff;
    logic irq_take_ff;
    logic bus_en_ff;
    pst_clk_en_t clk_en_ff;
    pst_txn_t txn_ff;

    function automatic logic sync_out(input logic [SYNC_STAGES-1:0] s);
        sync_out = s[SYNC_STAGES-1];
    endfunction

    // snoops and interrupts need the bus and apic clocks running
    function automatic logic can_service(input pst_state_t s);
        can_service = s != PST_SLEEP && s != PST_TRIP;
    endfunction

    // a hot reset must not restart execution, so reset lands in trip
    function automatic pst_state_t reset_state(input logic hot);
        reset_state = hot ? PST_TRIP : PST_RUN;
    endfunction

    // stop grant keeps bus and apic clocks
    function automatic pst_clk_en_t clk_en_for(input pst_state_t s);
        case (s)
            PST_STOP_GRANT: clk_en_for = '{core: 1'b0, bus_unit: 1'b1, apic: 1'b1};
            PST_SLEEP: clk_en_for = '{core: 1'b0, bus_unit: 1'b0, apic: 1'b0};
            PST_TRIP: clk_en_for = '{core: 1'b0, bus_unit: 1'b0, apic: 1'b0};
            default: clk_en_for = '{core: 1'b1, bus_unit: 1'b1, apic: 1'b1};
        endcase
    endfunction

    // stop request resynchronised, no clock touched
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            stop_sync_ff <= SYNC_RESET_VAL;
        end else begin
            stop_sync_ff <= {stop_sync_ff[SYNC_STAGES-2:0], i_stop_clock_request_n};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sleep_sync_ff <= SYNC_RESET_VAL;
        end else begin
            sleep_sync_ff <= {sleep_sync_ff[SYNC_STAGES-2:0], i_sleep_request_n};
        end
    end

    // no timing relation assumed on the request
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            smi_sync_ff <= SYNC_RESET_VAL;
        end else begin
            smi_sync_ff <= {smi_sync_ff[SYNC_STAGES-2:0], i_mgmt_interrupt_n};
        end
    end

    assign stop_req = !sync_out(stop_sync_ff);
    assign sleep_req = !sync_out(sleep_sync_ff);
    assign smi_req = !sync_out(smi_sync_ff);

    // trip latch, cleared only by reset
    // reset cannot clear while still hot
    always_ff @(posedge i_core_clk) begin
        if (i_over_trip_temp) begin
            trip_ff <= 1'b1;
        end else if (i_sys_rst) begin
            trip_ff <= 1'b0;
        end
    end

    // edge detect; idle after reset means no request, so no false edge
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            smi_prev_ff <= 1'b0;
        end else begin
            smi_prev_ff <= smi_req;
        end
    end

    // management request edge is held pending; sleep defers it until stop grant exits
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            smi_pend_ff <= 1'b0;
        end else if (smi_req && !smi_prev_ff) begin
            smi_pend_ff <= 1'b1;
        end else if (state_ff == PST_SMI_SAVE) begin
            smi_pend_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PST_RUN: begin
                if (smi_pend_ff && !smm_ff) begin
                    nxt_state = PST_SMI_SAVE;
                end else if (stop_req) begin
                    nxt_state = PST_GRANT_ACK;
                end
            end
            PST_GRANT_ACK: begin
                if (i_txn_ready) begin
                    nxt_state = PST_STOP_GRANT;
                end
            end
            PST_STOP_GRANT: begin
                if (sleep_req) begin
                    nxt_state = PST_SLEEP;
                end else if (!stop_req) begin
                    nxt_state = PST_RUN;
                end
            end
            // sleep release back to stop grant
            PST_SLEEP: begin
                if (!sleep_req) begin
                    nxt_state = PST_STOP_GRANT;
                end
            end
            PST_SMI_SAVE: nxt_state = PST_SMI_ACK;
            PST_SMI_ACK: begin
                if (i_txn_ready) begin
                    nxt_state = PST_RUN;
                end
            end
            PST_TRIP: nxt_state = PST_TRIP;
            default: nxt_state = PST_RUN;
        endcase
        if (trip_ff || i_over_trip_temp) begin
            nxt_state = PST_TRIP;
        end
    end

    // reset returns to run at the vector, or to trip while still hot
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_ff <= reset_state(i_over_trip_temp);
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            smm_ff <= 1'b0;
        end else if (state_ff == PST_SMI_SAVE) begin
            smm_ff <= 1'b1;
        end
    end

    // marks the first edge out of reset so the vector fetch fires once
    always_ff @(posedge i_core_clk) begin
        rst_seen_ff <= i_sys_rst;
    end

    // first fetch after cool reset at vector
    always_ff @(posedge i_core_clk) begin
        fetch_ff <= 1'b0;
        if (i_sys_rst) begin
            fetch_addr_ff <= RESET_VECTOR;
        end else if (rst_seen_ff && state_ff == PST_RUN) begin
            fetch_ff <= 1'b1;
            fetch_addr_ff <= RESET_VECTOR;
        end else if (state_ff == PST_SMI_ACK && i_txn_ready && !trip_ff && !i_over_trip_temp) begin
            // handler entry point is outside this block; flag marks the start
            fetch_ff <= 1'b1;
        end
    end

    // stop grant keeps bus and apic; leaving sleep restarts them
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            clk_en_ff <= clk_en_for(reset_state(i_over_trip_temp));
        end else begin
            clk_en_ff <= clk_en_for(nxt_state);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            snoop_ack_ff <= 1'b0;
        end else begin
            snoop_ack_ff <= i_snoop_req && can_service(state_ff);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            irq_take_ff <= 1'b0;
        end else begin
            irq_take_ff <= i_irq_req && can_service(state_ff);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            txn_ff <= '{valid: 1'b0, code: TXN_NONE};
        end else if (nxt_state == PST_GRANT_ACK && !(state_ff == PST_GRANT_ACK && i_txn_ready)) begin
            txn_ff <= '{valid: 1'b1, code: TXN_STOP_GRANT_ACK};
        end else if (nxt_state == PST_SMI_ACK) begin
            txn_ff <= '{valid: 1'b1, code: TXN_SMI_ACK};
        end else begin
            txn_ff <= '{valid: 1'b0, code: TXN_NONE};
        end
    end

    // bus outputs off in the same cycle reset is seen
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            bus_en_ff <= 1'b0;
        end else begin
            bus_en_ff <= nxt_state != PST_TRIP;
        end
    end

    assign o_overheat_trip_n = !trip_ff;
    assign o_exec_en = state_ff == PST_RUN && !i_sys_rst;
    assign o_fetch_start = fetch_ff;
    assign o_fetch_addr = fetch_addr_ff;
    assign o_save_state = state_ff == PST_SMI_SAVE;
    assign o_system_management_mode = smm_ff;
    assign o_snoop_ack = snoop_ack_ff;
    assign o_irq_take = irq_take_ff;
    assign o_bus_out_en = bus_en_ff && !i_sys_rst ? 1'b1 : 1'b0;
    assign o_clk_en = clk_en_ff;
    assign o_txn = i_sys_rst ? pst_txn_t'{valid: 1'b0, code: TXN_NONE} : txn_ff;
endmodule
`default_nettype wire

// ==== sim/pst_ctrl_sva.sv ====
// pst_ctrl_sva: port checks for the power-state controller
// assumes one core clock and a synchronous active-high reset
`default_nettype none
module pst_ctrl_sva
    import pst_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_stop_clock_request_n,
    input wire logic i_over_trip_temp,
    input wire logic i_txn_ready,
    input wire logic i_irq_req,
    input wire logic o_overheat_trip_n,
    input wire logic o_exec_en,
    input wire logic o_fetch_start,
    input wire logic [35:0] o_fetch_addr,
    input wire logic o_save_state,
    input wire logic o_system_management_mode,
    input wire logic o_irq_take,
    input wire logic o_bus_out_en,
    input wire pst_clk_en_t o_clk_en,
    input wire pst_txn_t o_txn
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    property p_grant_gate; o_txn.valid && o_txn.code == TXN_STOP_GRANT_ACK && i_txn_ready |=> o_clk_en == 3'h3;
    endproperty
    a_grant_gate: assert property (p_grant_gate) else $error("grant gating");
    // three sync flops hold the request back at least three edges
    property p_stop_sync; $fell(i_stop_clock_request_n) && o_exec_en |-> (!o_txn.valid)[*3] ##[1:4] o_txn.valid;
    endproperty
    a_stop_sync: assert property (p_stop_sync) else $error("stop timing");
    property p_trip_set; disable iff (1'b0) i_over_trip_temp |=> !o_overheat_trip_n && !o_exec_en;
    endproperty
    a_trip_set: assert property (p_trip_set) else $error("trip late");
    property p_trip_hold; !o_overheat_trip_n |=> !o_overheat_trip_n && !o_exec_en;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip lost");
    property p_bus_release; disable iff (1'b0) i_sys_rst ##1 i_sys_rst |-> !o_bus_out_en && !o_txn.valid;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus not off");
    property p_vector; $fell(i_sys_rst) && !i_over_trip_temp |-> ##[0:2] o_fetch_start && o_fetch_addr == RESET_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("no vector");
    property p_smi_ack; o_save_state |=> o_system_management_mode && o_txn.valid && o_txn.code == TXN_SMI_ACK;
    endproperty
    a_smi_ack: assert property (p_smi_ack) else $error("smi ack");
    property p_sleep_irq; o_clk_en == 3'h0 && i_irq_req |=> !o_irq_take;
    endproperty
    a_sleep_irq: assert property (p_sleep_irq) else $error("irq in sleep");
endmodule
bind pst_ctrl pst_ctrl_sva i_sva (.i_core_clk, .i_sys_rst, .i_stop_clock_request_n, .i_over_trip_temp, .i_txn_ready,
    .i_irq_req, .o_overheat_trip_n, .o_exec_en, .o_fetch_start, .o_fetch_addr, .o_save_state,
    .o_system_management_mode, .o_irq_take, .o_bus_out_en, .o_clk_en, .o_txn);
`default_nettype wire

// ==== sim/pst_chipset.sv ====
// pst_chipset: system-side model that accepts acknowledge transactions
// assumes the shared core clock; i_wait_clks sets how slowly it answers
`default_nettype none
module pst_chipset
    import pst_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_wait_clks,
    input wire pst_txn_t i_txn,
    output logic o_txn_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_ff;
    // take acknowledges; ready lasts one edge so no request is taken twice
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !i_txn.valid || o_txn_ready) begin
            wait_ff <= 4'h0;
            o_txn_ready <= 1'b0;
        end else if (wait_ff >= i_wait_clks) begin
            o_txn_ready <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// tb_top: scenario bench for the power-state controller
// assumes pst_chipset answers the acknowledge cycles
`default_nettype none
module tb_top
    import pst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_stop_clock_request_n = 1'b1, i_sleep_request_n = 1'b1;
    logic i_mgmt_interrupt_n = 1'b1, i_over_trip_temp = 1'b0, i_snoop_req = 1'b0, i_irq_req = 1'b0;
    logic i_txn_ready, o_overheat_trip_n, o_exec_en, o_fetch_start, o_save_state, o_system_management_mode;
    logic o_snoop_ack, o_irq_take, o_bus_out_en;
    logic [3:0] wait_clks = 4'h0;
    logic [35:0] o_fetch_addr;
    pst_clk_en_t o_clk_en;
    pst_txn_t o_txn;
    int num_errors = 0, comparisons = 0, cycles = 0, k;
    pst_ctrl i_dut (.i_core_clk, .i_sys_rst, .i_stop_clock_request_n, .i_sleep_request_n, .i_mgmt_interrupt_n,
        .i_over_trip_temp, .i_txn_ready, .i_snoop_req, .i_irq_req, .o_overheat_trip_n, .o_exec_en, .o_fetch_start,
        .o_fetch_addr, .o_save_state, .o_system_management_mode, .o_snoop_ack, .o_irq_take, .o_bus_out_en,
        .o_clk_en, .o_txn);
    pst_chipset i_chip (.i_core_clk, .i_sys_rst, .i_wait_clks(wait_clks), .i_txn(o_txn), .o_txn_ready(i_txn_ready));
    initial forever #5 i_core_clk = ~i_core_clk;
    task automatic test_done();
        $display("compares %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // a hang is counted as a mismatch
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles > 3000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            test_done();
        end
    end
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic poke(input logic exp);
        {i_snoop_req, i_irq_req} = 2'h3;
        @(negedge i_core_clk);
        {i_snoop_req, i_irq_req} = 2'h0;
        chk(o_snoop_ack === exp && o_irq_take === exp, "snoop/irq");
    endtask
    task automatic t_reset();
        i_sys_rst = 1'b1;
        repeat (5) @(negedge i_core_clk);
        chk(o_bus_out_en === 1'b0 && o_txn.valid === 1'b0, "bus in reset");
        i_sys_rst = 1'b0;
        for (k = 0; k < 4 && o_fetch_start !== 1'b1; k++) @(negedge i_core_clk);
        chk(o_fetch_start === 1'b1 && o_fetch_addr === RESET_VECTOR, "vector");
        chk(o_bus_out_en === 1'b1, "bus on");
        repeat (4) @(negedge i_core_clk);
        $display("reset test done");
    endtask
    task automatic t_stop();
        wait_clks = 4'h3;
        i_sleep_request_n = 1'b0;
        repeat (8) @(negedge i_core_clk);
        chk(o_clk_en === 3'h7 && o_exec_en === 1'b1, "early sleep");
        i_sleep_request_n = 1'b1;
        i_stop_clock_request_n = 1'b0;
        for (k = 0; k < 20 && o_txn.valid !== 1'b1; k++) @(negedge i_core_clk);
        chk(o_txn === {1'b1, TXN_STOP_GRANT_ACK} && o_clk_en === 3'h7, "grant ack");
        for (k = 0; k < 20 && o_clk_en.core !== 1'b0; k++) @(negedge i_core_clk);
        chk(o_clk_en === 3'h3 && o_exec_en === 1'b0, "grant");
        poke(1'b1);
        i_sleep_request_n = 1'b0;
        for (k = 0; k < 20 && o_clk_en !== 3'h0; k++) @(negedge i_core_clk);
        chk(o_clk_en === 3'h0, "sleep");
        poke(1'b0);
        i_sleep_request_n = 1'b1;
        for (k = 0; k < 20 && o_clk_en !== 3'h3; k++) @(negedge i_core_clk);
        chk(o_clk_en === 3'h3, "wake");
        i_stop_clock_request_n = 1'b1;
        for (k = 0; k < 20 && o_exec_en !== 1'b1; k++) @(negedge i_core_clk);
        chk(o_clk_en === 3'h7 && o_exec_en === 1'b1, "resume");
        $display("stop test done");
    endtask
    task automatic t_smi();
        logic seen;
        wait_clks = 4'h6;
        i_mgmt_interrupt_n = 1'b0;
        for (k = 0; k < 20 && o_save_state !== 1'b1; k++) @(negedge i_core_clk);
        chk(o_save_state === 1'b1, "save");
        @(negedge i_core_clk);
        chk(o_system_management_mode === 1'b1 && o_txn === {1'b1, TXN_SMI_ACK}, "smi ack");
        for (k = 0; k < 20 && o_fetch_start !== 1'b1; k++) @(negedge i_core_clk);
        chk(o_fetch_start === 1'b1, "handler");
        i_mgmt_interrupt_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        i_mgmt_interrupt_n = 1'b0;
        seen = 1'b0;
        repeat (8) begin
            @(negedge i_core_clk);
            seen = seen | o_save_state;
        end
        chk(seen === 1'b0 && o_system_management_mode === 1'b1, "smi in smm");
        i_mgmt_interrupt_n = 1'b1;
        $display("smi test done");
    endtask
    task automatic t_trip();
        i_over_trip_temp = 1'b1;
        @(negedge i_core_clk);
        chk(o_overheat_trip_n === 1'b0 && o_exec_en === 1'b0 && o_bus_out_en === 1'b0, "trip");
        i_over_trip_temp = 1'b0;
        repeat (10) @(negedge i_core_clk);
        chk(o_overheat_trip_n === 1'b0 && o_exec_en === 1'b0, "latched");
        {i_over_trip_temp, i_sys_rst} = 2'h3;
        repeat (3) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        repeat (3) @(negedge i_core_clk);
        chk(o_overheat_trip_n === 1'b0 && o_exec_en === 1'b0, "hot reset");
        i_over_trip_temp = 1'b0;
        t_reset();
        chk(o_overheat_trip_n === 1'b1 && o_exec_en === 1'b1 && o_system_management_mode === 1'b0, "restart");
        $display("trip test done");
    endtask
    initial begin
        t_reset();
        t_stop();
        t_smi();
        t_trip();
        test_done();
    end
endmodule
`default_nettype wire
